// >>> src/suvm_defines.vh
// constants for the supply undervoltage and mode control block
`ifndef SUVM_DEFINES_VH
`define SUVM_DEFINES_VH

// clock rate in kHz (50 MHz)
`define SUVM_CLK_KHZ 50000
// microseconds per millisecond: microseconds times kHz over this gives clock cycles
`define SUVM_US_PER_MS 1000
// times in microseconds; counts are derived in the modules
`define SUVM_BAT_BLANK_US 10
`define SUVM_CORE_BLANK_US 10
`define SUVM_REF_BLANK_US 10
`define SUVM_DETECT_US 100
`define SUVM_RECOVER_US 100
`define SUVM_REACT_US 2
`define SUVM_POWERUP_US 50
`define SUVM_CNT_W 16

// avalon register byte addresses
`define SUVM_ADDR_W 4
`define SUVM_OFS_STATUS 4'h0
`define SUVM_OFS_MODE 4'h4
`define SUVM_OFS_CMD 4'h8
`define SUVM_OFS_CLEAR 4'hC

// status info register fields
`define SUVM_BIT_BUSERR 4
`define SUVM_BIT_BAT 8
`define SUVM_BIT_CORE 9
`define SUVM_BIT_REF 10
`define SUVM_BIT_ERR 11
// mode register fields
`define SUVM_BIT_FLAG_BAT 4
`define SUVM_BIT_FLAG_CORE 5
`define SUVM_BIT_FLAG_REF 6
`define SUVM_BIT_HOST_BLK 7
`define SUVM_BIT_CC_BLK 8
`define SUVM_BIT_REF_BLK 9
`define SUVM_CLEAR_KEY 32'h0000FFFF

// operating modes
`define SUVM_MODE_W 3
`define SUVM_MODE_OFF 3'h0
`define SUVM_MODE_INTERIM 3'h1
`define SUVM_MODE_STANDBY 3'h2
`define SUVM_MODE_SLEEP 3'h3
`define SUVM_MODE_NORMAL 3'h4
`define SUVM_MODE_RXONLY 3'h5

`endif

// >>> src/suvm_filter.v
// blanking filter: output rises after the below input is high for more than the blanking count
`timescale 1ns/1ps
`include "suvm_defines.vh"
module suvm_filter #(
	parameter [`SUVM_CNT_W-1:0] BLANK = 16'h0001
) (
	input wire ref_clk,
	input wire rst,
	input wire clr,
	input wire below,
	output reg event_on
);
	reg [`SUVM_CNT_W-1:0] cnt;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 16'h0000;
			event_on <= 1'b0;
		end else if (clr || !below) begin
			// short dips reset the count and are ignored
			cnt <= 16'h0000;
			event_on <= 1'b0;
		end else if (cnt < BLANK) begin
			cnt <= cnt + 16'h0001;
		end else begin
			event_on <= 1'b1;
		end
	end
endmodule

// >>> src/suvm_uv_timer.v
// detection and recovery timers producing one undervoltage flag
`timescale 1ns/1ps
`include "suvm_defines.vh"
module suvm_uv_timer #(
	parameter [`SUVM_CNT_W-1:0] DETECT = 16'h0001,
	parameter [`SUVM_CNT_W-1:0] RECOVER = 16'h0001
) (
	input wire ref_clk,
	input wire rst,
	input wire clr,
	input wire uv_event,
	output reg flag
);
	reg [`SUVM_CNT_W-1:0] cnt;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 16'h0000;
			flag <= 1'b0;
		end else if (clr) begin
			cnt <= 16'h0000;
			flag <= 1'b0;
		end else if (!flag) begin
			if (!uv_event) begin
				cnt <= 16'h0000;
			end else if (cnt < DETECT) begin
				cnt <= cnt + 16'h0001;
			end else begin
				cnt <= 16'h0000;
				flag <= 1'b1;
			end
		end else begin
			if (uv_event) begin
				cnt <= 16'h0000;
			end else if (cnt < RECOVER) begin
				cnt <= cnt + 16'h0001;
			end else begin
				cnt <= 16'h0000;
				flag <= 1'b0;
			end
		end
	end
endmodule

// >>> src/suvm_core.v
// supply supervision, status bits and operating mode control with avalon slave
//
// How it works
// - battery dip counts as event only after lasting past battery blanking time.
// - qualified battery event sets status bit 8 and error bit 11 at once.
// - battery detect timer expiry sets battery flag and enters sleep mode.
// - host and controller interfaces run during battery timing; blocked while flag set.
// - core dip counts as event only after lasting past core blanking time.
// - qualified core event sets status bit 9 and error bit 11.
// - host interface stays usable while core detect timer runs.
// - core timer expiry sets core flag, blocks host, forces standby.
// - during core undervoltage transmitter is off and bus error bit 4 set.
// - reference supply events are handled like battery events.
// - after reaction delay, reference event blocks all interfaces, inputs defaulted.
// - during reference undervoltage every digital output is held low.
// - reference event only after dip lasts past reference blanking time.
// - reference event sets bits 10 and 11; timer expiry sets flag, sleep.
// - unpowered only when battery and core both below power-down thresholds.
// - unpowered state drives outputs low, transmitter and receiver off.
// - logic powers up as soon as battery or core passes reset threshold.
// - with both supplies good, standby is entered within power-up time.
// - incomplete power-up gives interim standby where host commands are rejected.
// - interim standby runs detect timers; completion gives standby, expiry low power.
// - event vanishing while detect timer runs leaves the flag clear.
// - recovery timer clears flag and restores commanded mode; relapse keeps flag.
// - status bits clear only on power-down or a full status clear.
// - unpowered state resets all status and failure information.
`timescale 1ns/1ps
`include "suvm_defines.vh"
module suvm_core (
	input wire ref_clk,
	input wire rst,
	input wire battery_below_uv,
	input wire core_below_uv,
	input wire ref_below_uv,
	input wire battery_below_pd,
	input wire core_below_pd,
	input wire [`SUVM_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire tx_data_in,
	output reg tx_enable,
	output reg rx_enable,
	output reg error_indicator_out,
	output reg receive_activity_out,
	output reg inhibit_out,
	output reg [`SUVM_MODE_W-1:0] mode,
	output reg host_blocked,
	output reg cc_blocked,
	output reg guardian_blocked,
	output reg inputs_defaulted
);
	// counts are worked out at integer width, then cut to the counter width on purpose
	localparam integer BAT_BLANK_I =
		(`SUVM_BAT_BLANK_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer CORE_BLANK_I =
		(`SUVM_CORE_BLANK_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer REF_BLANK_I =
		(`SUVM_REF_BLANK_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer DETECT_I =
		(`SUVM_DETECT_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer RECOVER_I =
		(`SUVM_RECOVER_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer REACT_I =
		(`SUVM_REACT_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam integer POWERUP_I =
		(`SUVM_POWERUP_US * `SUVM_CLK_KHZ) / `SUVM_US_PER_MS;
	localparam [`SUVM_CNT_W-1:0] BAT_BLANK = BAT_BLANK_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] CORE_BLANK = CORE_BLANK_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] REF_BLANK = REF_BLANK_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] DETECT = DETECT_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] RECOVER = RECOVER_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] REACT = REACT_I[`SUVM_CNT_W-1:0];
	localparam [`SUVM_CNT_W-1:0] POWERUP = POWERUP_I[`SUVM_CNT_W-1:0];

	wire powered_down;
	wire bat_event;
	wire core_event;
	wire ref_event;
	wire bat_flag;
	wire core_flag;
	wire ref_flag;
	wire any_flag;
	wire sel_status;
	wire sel_mode;
	wire sel_cmd;
	wire sel_clear;
	wire cmd_ok;
	reg [11:0] status;
	reg [`SUVM_MODE_W-1:0] next_mode;
	reg [`SUVM_MODE_W-1:0] commanded;
	reg [`SUVM_CNT_W-1:0] pu_cnt;
	reg [`SUVM_CNT_W-1:0] react_cnt;
	reg ref_blocked;
	reg rd_pending;

	// both supplies under power-down threshold; reference has no say here
	assign powered_down = battery_below_pd & core_below_pd;

	// power-down acts as a synchronous clear of every stateful part except the avalon read registers
	suvm_filter #(.BLANK(BAT_BLANK)) u_bat_filt (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.below(battery_below_uv),
		.event_on(bat_event)
	);
	suvm_filter #(.BLANK(CORE_BLANK)) u_core_filt (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.below(core_below_uv),
		.event_on(core_event)
	);
	suvm_filter #(.BLANK(REF_BLANK)) u_ref_filt (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.below(ref_below_uv),
		.event_on(ref_event)
	);

	// detect timer resets if the event vanishes early, recovery restarts on relapse
	suvm_uv_timer #(.DETECT(DETECT), .RECOVER(RECOVER)) u_bat_tmr (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.uv_event(bat_event),
		.flag(bat_flag)
	);
	suvm_uv_timer #(.DETECT(DETECT), .RECOVER(RECOVER)) u_core_tmr (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.uv_event(core_event),
		.flag(core_flag)
	);
	suvm_uv_timer #(.DETECT(DETECT), .RECOVER(RECOVER)) u_ref_tmr (
		.ref_clk(ref_clk),
		.rst(rst),
		.clr(powered_down),
		.uv_event(ref_event),
		.flag(ref_flag)
	);

	// any active flag shuts out host commands until its recovery timer ends
	assign any_flag = bat_flag | core_flag | ref_flag;

	// avalon slave: one wait cycle on reads so read data come from a register
	assign sel_status = (avs_address == `SUVM_OFS_STATUS);
	assign sel_mode = (avs_address == `SUVM_OFS_MODE);
	assign sel_cmd = (avs_address == `SUVM_OFS_CMD);
	assign sel_clear = (avs_address == `SUVM_OFS_CLEAR);
	assign avs_waitrequest = avs_read & ~rd_pending;

	// host commands need the host side open and a stable operating mode
	assign cmd_ok = avs_write & sel_cmd & ~host_blocked & ~any_flag & ~powered_down
		& (mode != `SUVM_MODE_INTERIM) & (mode != `SUVM_MODE_OFF);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_pending <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !rd_pending) begin
			rd_pending <= 1'b1;
			if (sel_status) begin
				avs_readdata <= {20'h00000, status};
			end else if (sel_mode) begin
				// blocks at bits 9..7, flags at 6..4, mode code at 2..0
				avs_readdata <= {22'h000000, ref_blocked, cc_blocked, host_blocked,
					ref_flag, core_flag, bat_flag, 1'b0, mode};
			end else if (sel_cmd) begin
				avs_readdata <= {29'h00000000, commanded};
			end else begin
				avs_readdata <= 32'h00000000;
			end
		end else begin
			rd_pending <= 1'b0;
		end
	end

	// latched status bits: set wins over a key clear in the same cycle; power-down clears over a set
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status <= 12'h000;
		end else if (powered_down) begin
			status <= 12'h000;
		end else begin
			// only the full key clears, so a stray write cannot wipe the history
			if (avs_write && sel_clear && avs_writedata == `SUVM_CLEAR_KEY) begin
				status <= 12'h000;
			end
			if (bat_event) begin
				status[`SUVM_BIT_BAT] <= 1'b1;
				status[`SUVM_BIT_ERR] <= 1'b1;
			end
			if (core_event) begin
				status[`SUVM_BIT_CORE] <= 1'b1;
				status[`SUVM_BIT_ERR] <= 1'b1;
				status[`SUVM_BIT_BUSERR] <= 1'b1;
			end
			if (ref_event) begin
				status[`SUVM_BIT_REF] <= 1'b1;
				status[`SUVM_BIT_ERR] <= 1'b1;
			end
		end
	end

	// reaction delay before reference undervoltage blocks the interfaces
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			react_cnt <= 16'h0000;
			ref_blocked <= 1'b0;
		end else if (powered_down || !ref_event) begin
			// a dip that ends early restarts the delay from zero
			react_cnt <= 16'h0000;
			ref_blocked <= 1'b0;
		end else if (react_cnt < REACT) begin
			react_cnt <= react_cnt + 16'h0001;
		end else begin
			ref_blocked <= 1'b1;
		end
	end

	// last mode the host asked for, restored once all flags clear
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			commanded <= `SUVM_MODE_STANDBY;
		end else if (powered_down) begin
			commanded <= `SUVM_MODE_STANDBY;
		end else if (cmd_ok) begin
			// codes outside the commandable set keep the last command
			if (avs_writedata[2:0] == `SUVM_MODE_NORMAL
				|| avs_writedata[2:0] == `SUVM_MODE_RXONLY
				|| avs_writedata[2:0] == `SUVM_MODE_STANDBY
				|| avs_writedata[2:0] == `SUVM_MODE_SLEEP) begin
				commanded <= avs_writedata[2:0];
			end
		end
	end

	// power-up timer runs while the logic is powered and not yet settled
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pu_cnt <= 16'h0000;
		// held at zero while both supplies are down, so the time starts at recovery
		end else if (mode != `SUVM_MODE_OFF || powered_down) begin
			pu_cnt <= 16'h0000;
		end else if (pu_cnt < POWERUP) begin
			pu_cnt <= pu_cnt + 16'h0001;
		end
	end

	always @* begin
		next_mode = mode;
		case (mode)
			`SUVM_MODE_OFF: begin
				// either supply over reset threshold wakes the logic
				if (!powered_down) begin
					if (!battery_below_uv && !core_below_uv) begin
						next_mode = `SUVM_MODE_STANDBY;
					end else if (pu_cnt >= POWERUP) begin
						next_mode = `SUVM_MODE_INTERIM;
					end
				end
			end
			`SUVM_MODE_INTERIM: begin
				if (bat_flag || ref_flag) begin
					next_mode = `SUVM_MODE_SLEEP;
				end else if (core_flag) begin
					next_mode = `SUVM_MODE_STANDBY;
				end else if (!battery_below_uv && !core_below_uv) begin
					next_mode = `SUVM_MODE_STANDBY;
				end
			end
			default: begin
				if (bat_flag || ref_flag) begin
					next_mode = `SUVM_MODE_SLEEP;
				end else if (core_flag) begin
					next_mode = `SUVM_MODE_STANDBY;
				end else begin
					next_mode = commanded;
				end
			end
		endcase
		if (powered_down) begin
			next_mode = `SUVM_MODE_OFF;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode <= `SUVM_MODE_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	// blocking and pin outputs; pins low and every block set in the unpowered state
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			host_blocked <= 1'b1;
			cc_blocked <= 1'b1;
			guardian_blocked <= 1'b1;
			inputs_defaulted <= 1'b1;
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			error_indicator_out <= 1'b0;
			receive_activity_out <= 1'b0;
			inhibit_out <= 1'b0;
		end else begin
			host_blocked <= ref_blocked | bat_flag | ref_flag | core_flag
				| (mode == `SUVM_MODE_OFF);
			cc_blocked <= ref_blocked | bat_flag | ref_flag
				| (mode == `SUVM_MODE_OFF);
			guardian_blocked <= ref_blocked | (mode == `SUVM_MODE_OFF);
			inputs_defaulted <= ref_blocked | (mode == `SUVM_MODE_OFF);
			// power-down drops the pins at the same edge at which mode goes off
			if (mode == `SUVM_MODE_OFF || powered_down || ref_event) begin
				tx_enable <= 1'b0;
				rx_enable <= 1'b0;
				error_indicator_out <= 1'b0;
				receive_activity_out <= 1'b0;
				inhibit_out <= 1'b0;
			end else begin
				tx_enable <= (mode == `SUVM_MODE_NORMAL) & ~core_event & tx_data_in;
				rx_enable <= (mode == `SUVM_MODE_NORMAL) | (mode == `SUVM_MODE_RXONLY);
				// error output is active low: low means an error is latched
				error_indicator_out <= ~status[`SUVM_BIT_ERR];
				receive_activity_out <= (mode == `SUVM_MODE_NORMAL)
					| (mode == `SUVM_MODE_RXONLY);
				inhibit_out <= (mode != `SUVM_MODE_SLEEP);
			end
		end
	end
endmodule

// >>> verif/suvm_core_monitor.sv
// concurrent checks on the supply supervision block ports
`timescale 1ns/1ps
`include "suvm_defines.vh"
module suvm_core_monitor (
	input wire ref_clk,
	input wire rst,
	input wire battery_below_uv,
	input wire core_below_uv,
	input wire ref_below_uv,
	input wire battery_below_pd,
	input wire core_below_pd,
	input wire [`SUVM_ADDR_W-1:0] avs_address,
	input wire avs_write,
	input wire tx_enable,
	input wire rx_enable,
	input wire error_indicator_out,
	input wire receive_activity_out,
	input wire inhibit_out,
	input wire [`SUVM_MODE_W-1:0] mode,
	input wire host_blocked,
	input wire cc_blocked,
	input wire guardian_blocked,
	input wire inputs_defaulted
);
	localparam int BLK = `SUVM_BAT_BLANK_US * `SUVM_CLK_KHZ / `SUVM_US_PER_MS;
	localparam int DET = `SUVM_DETECT_US * `SUVM_CLK_KHZ / `SUVM_US_PER_MS;
	localparam int RCT = `SUVM_REACT_US * `SUVM_CLK_KHZ / `SUVM_US_PER_MS;
	localparam int PWR = `SUVM_POWERUP_US * `SUVM_CLK_KHZ / `SUVM_US_PER_MS;
	logic [15:0] bat_cnt;
	logic [15:0] core_cnt;
	logic [15:0] ref_cnt;
	logic [15:0] off_cnt;
	wire pd_any = battery_below_pd | core_below_pd;
	wire good = !battery_below_uv && !core_below_uv && !(battery_below_pd && core_below_pd);
	// saturating so a long dip never wraps back into the short-dip range
	function automatic logic [15:0] inc(input logic [15:0] v);
		inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bat_cnt <= 16'h0000;
			core_cnt <= 16'h0000;
			ref_cnt <= 16'h0000;
			off_cnt <= 16'h0000;
		end else begin
			bat_cnt <= battery_below_uv ? inc(bat_cnt) : 16'h0000;
			core_cnt <= core_below_uv ? inc(core_cnt) : 16'h0000;
			ref_cnt <= ref_below_uv ? inc(ref_cnt) : 16'h0000;
			off_cnt <= (mode == `SUVM_MODE_OFF && good) ? inc(off_cnt) : 16'h0000;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_pd_mode_off: assert property (battery_below_pd && core_below_pd |=> mode == `SUVM_MODE_OFF)
		else $error("mode not off after power-down");
	a_pd_out_low: assert property (battery_below_pd && core_below_pd |=>
		!(tx_enable | rx_enable | error_indicator_out | receive_activity_out | inhibit_out))
		else $error("output high in unpowered state");
	a_powerup_time: assert property (off_cnt <= PWR + 4)
		else $error("standby not reached within power-up time");
	a_core_tx_off: assert property (core_cnt > BLK + 3 |-> !tx_enable)
		else $error("transmitter on during core undervoltage");
	a_ref_out_low: assert property (ref_cnt > BLK + 3 |->
		!(error_indicator_out | receive_activity_out | rx_enable))
		else $error("output high during reference undervoltage");
	a_ref_block_all: assert property (ref_cnt > BLK + RCT + 3 && !pd_any |->
		host_blocked && cc_blocked && guardian_blocked && inputs_defaulted)
		else $error("interfaces not blocked after reference undervoltage");
	a_bat_sleep: assert property (bat_cnt > BLK + DET + 8 && !core_below_uv && !ref_below_uv && !pd_any
		|-> mode == `SUVM_MODE_SLEEP && host_blocked && cc_blocked)
		else $error("battery flag did not force sleep");
	a_core_standby: assert property (core_cnt > BLK + DET + 8 && !battery_below_uv && !ref_below_uv
		&& !pd_any |-> mode == `SUVM_MODE_STANDBY && host_blocked)
		else $error("core flag did not force standby");
	a_interim_cmd: assert property (mode == `SUVM_MODE_INTERIM && avs_write && avs_address == `SUVM_OFS_CMD
		|=> mode != `SUVM_MODE_NORMAL && mode != `SUVM_MODE_RXONLY)
		else $error("host command accepted in interim standby");
endmodule
bind suvm_core suvm_core_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
	.battery_below_uv(battery_below_uv), .core_below_uv(core_below_uv),
	.ref_below_uv(ref_below_uv), .battery_below_pd(battery_below_pd),
	.core_below_pd(core_below_pd), .avs_address(avs_address), .avs_write(avs_write),
	.tx_enable(tx_enable), .rx_enable(rx_enable), .error_indicator_out(error_indicator_out),
	.receive_activity_out(receive_activity_out), .inhibit_out(inhibit_out), .mode(mode),
	.host_blocked(host_blocked), .cc_blocked(cc_blocked), .guardian_blocked(guardian_blocked),
	.inputs_defaulted(inputs_defaulted));

// >>> verif/suvm_host_model.sv
// communication controller stand-in: keeps the transmit request line busy
`timescale 1ns/1ps
module suvm_host_model (
	input wire ref_clk,
	input wire rst,
	output logic tx_data_in
);
	// toggling every cycle so a stuck transmitter gate cannot pass by chance
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_data_in <= 1'b0;
		end else begin
			tx_data_in <= ~tx_data_in;
		end
	end
endmodule

// >>> verif/tb.sv
// scenario bench for the supply supervision and mode control block
`timescale 1ns/1ps
`include "suvm_defines.vh"
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] uv = 3'h0;
	logic [1:0] pd = 2'h0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, tx_data_in, tx_enable, rx_enable, error_indicator_out;
	wire receive_activity_out, inhibit_out, host_blocked, cc_blocked, guardian_blocked;
	wire inputs_defaulted;
	wire [2:0] mode;
	int err_count = 0;
	int n_compared = 0;
	suvm_core u_dut (.ref_clk(ref_clk), .rst(rst), .battery_below_uv(uv[0]),
		.core_below_uv(uv[1]), .ref_below_uv(uv[2]), .battery_below_pd(pd[0]),
		.core_below_pd(pd[1]), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_data_in(tx_data_in), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .error_indicator_out(error_indicator_out),
		.receive_activity_out(receive_activity_out), .inhibit_out(inhibit_out), .mode(mode),
		.host_blocked(host_blocked), .cc_blocked(cc_blocked), .guardian_blocked(guardian_blocked),
		.inputs_defaulted(inputs_defaulted));
	suvm_host_model u_host (.ref_clk(ref_clk), .rst(rst), .tx_data_in(tx_data_in));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		// only the watchdog ends a wait that never sees waitrequest low
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wait_mode(input logic [2:0] m, input int lim);
		int n;
		n = 0;
		while (mode !== m && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk(mode, m);
	endtask
	task automatic t_powerup;
		wait_mode(`SUVM_MODE_STANDBY, 2510);
		bus(1'b1, `SUVM_OFS_CMD, 32'h4);
		wait_mode(`SUVM_MODE_NORMAL, 10);
		bus(1'b0, `SUVM_OFS_MODE, 32'h0);
		chk(rd[2:0], `SUVM_MODE_NORMAL);
		// transmitter follows the toggling request one cycle late; no error latched yet
		chk({tx_enable ^ tx_data_in, rx_enable, receive_activity_out, inhibit_out,
			error_indicator_out}, 5'h1F);
		bus(1'b0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		$display("test powerup done");
	endtask
	task automatic t_battery;
		uv[0] <= 1'b1;
		cyc(400);
		uv[0] <= 1'b0;
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		uv[0] <= 1'b1;
		cyc(510);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'h900);
		chk(error_indicator_out, 1'b0);
		chk({host_blocked, cc_blocked, mode}, {2'b00, `SUVM_MODE_NORMAL});
		wait_mode(`SUVM_MODE_SLEEP, 5100);
		chk({host_blocked, cc_blocked}, 2'b11);
		cyc(1);
		chk(inhibit_out, 1'b0);
		uv[0] <= 1'b0;
		cyc(3000);
		uv[0] <= 1'b1;
		cyc(600);
		uv[0] <= 1'b0;
		cyc(4000);
		chk(mode, `SUVM_MODE_SLEEP);
		wait_mode(`SUVM_MODE_NORMAL, 1200);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'h900);
		bus(1'b1, `SUVM_OFS_CLEAR, `SUVM_CLEAR_KEY);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		chk(error_indicator_out, 1'b1);
		$display("test battery done");
	endtask
	task automatic t_core;
		uv[1] <= 1'b1;
		cyc(3000);
		chk({tx_enable, host_blocked, mode}, {2'b00, `SUVM_MODE_NORMAL});
		uv[1] <= 1'b0;
		cyc(5100);
		chk(mode, `SUVM_MODE_NORMAL);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'hA10);
		uv[1] <= 1'b1;
		wait_mode(`SUVM_MODE_STANDBY, 5600);
		chk(host_blocked, 1'b1);
		uv[1] <= 1'b0;
		wait_mode(`SUVM_MODE_NORMAL, 5200);
		bus(1'b1, `SUVM_OFS_CLEAR, `SUVM_CLEAR_KEY);
		$display("test core done");
	endtask
	task automatic t_reference;
		uv[2] <= 1'b1;
		cyc(400);
		uv[2] <= 1'b0;
		cyc(300);
		chk({host_blocked, mode}, {1'b0, `SUVM_MODE_NORMAL});
		uv[2] <= 1'b1;
		cyc(700);
		chk({host_blocked, cc_blocked, guardian_blocked, inputs_defaulted}, 4'hF);
		chk({error_indicator_out, receive_activity_out, rx_enable}, 3'h0);
		wait_mode(`SUVM_MODE_SLEEP, 5000);
		uv[2] <= 1'b0;
		wait_mode(`SUVM_MODE_NORMAL, 5200);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'hC00);
		$display("test reference done");
	endtask
	task automatic t_powerdown;
		pd <= 2'b01;
		cyc(5);
		chk(mode, `SUVM_MODE_NORMAL);
		pd <= 2'b11;
		cyc(3);
		chk(mode, `SUVM_MODE_OFF);
		chk({tx_enable, rx_enable, error_indicator_out, receive_activity_out, inhibit_out}, 5'h0);
		pd <= 2'b00;
		uv[1] <= 1'b1;
		wait_mode(`SUVM_MODE_INTERIM, 2600);
		bus(1'b1, `SUVM_OFS_CMD, 32'h4);
		cyc(3);
		chk(mode, `SUVM_MODE_INTERIM);
		uv[1] <= 1'b0;
		wait_mode(`SUVM_MODE_STANDBY, 2600);
		bus(1'b0, `SUVM_OFS_STATUS, 32'h0);
		chk(rd, 32'hA10);
		$display("test powerdown done");
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// the whole sequence needs about 47k cycles
	initial begin
		#1600000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_powerup();
		t_battery();
		t_core();
		t_reference();
		t_powerdown();
		report_and_stop();
	end
endmodule
